/* src/ases_consts.svh */
// constants for the arm/sequence event status block
// assumes 16-bit status registers, one system clock
`ifndef ASES_CONSTS_SVH
`define ASES_CONSTS_SVH

// register width
`define ASES_W 16
// field positions
`define ASES_LAYER1_BIT 1
`define ASES_SCAN_BIT 2
`define ASES_ARM_B1_BIT 1
`define ASES_WAIT_ARM_BIT 6
// reset and preset values
`define ASES_RISE_RST 16'hffff
`define ASES_FALL_RST 16'h0000
`define ASES_EVT_RST 16'h0000
`define ASES_MASK_RST 16'h0000
// condition bits that carry meaning
`define ASES_LAYER_DEF 16'h0006
`define ASES_ARM_DEF 16'h0002

`endif

/* src/ases_pkg.sv */
// types shared by the arm/sequence event status block
// assumes the command parser sends one decoded register access at a time
`default_nettype none

package ases_pkg;

	// register selected by a decoded status command
	typedef enum logic [3:0]
	{
		ASES_ARM_COND,
		ASES_ARM_RISE,
		ASES_ARM_FALL,
		ASES_ARM_EVT,
		ASES_ARM_MASK,
		ASES_LAYER_COND,
		ASES_LAYER_RISE,
		ASES_LAYER_FALL,
		ASES_LAYER_EVT,
		ASES_LAYER_MASK
	} ases_reg_e;

	// one decoded access from the command parser
	typedef struct packed
	{
		logic valid;
		logic write;
		ases_reg_e sel;
		logic [15:0] data;
	} ases_cmd_s;

	// one register set of the cascade
	typedef struct packed
	{
		logic [15:0] cond;
		logic [15:0] prev;
		logic [15:0] rise;
		logic [15:0] fall;
		logic [15:0] evt;
		logic [15:0] mask;
	} ases_set_s;

endpackage

`default_nettype wire

/* src/ases_top.sv */
// arm/sequence event status: two cascaded 16-bit status register sets
// assumes layer status levels come from another domain and commands
// arrive already decoded on sys_clk_i, at most one per enabled cycle
`include "ases_consts.svh"
`default_nettype none

module ases_top
(
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic clk_en_i,
	input wire logic in_arm_layer1_i,
	input wire logic in_scan_layer_i,
	input wire ases_pkg::ases_cmd_s cmd_i,
	input wire logic preset_i,
	input wire logic clear_status_i,
	output logic [15:0] rd_data_o,
	output logic rd_valid_o,
	output logic [15:0] oper_wait_arm_o
);

	////////////////////////////////////////////////////////////////////////
	// helpers

	// bits whose condition moved in a direction the filter allows
	function automatic logic [15:0] edge_hits(input logic [15:0] cond,
		input logic [15:0] prev, input logic [15:0] rise, input logic [15:0] fall);
		edge_hits = (cond & ~prev & rise) | (~cond & prev & fall);
	endfunction

	// a decoded access to one register this cycle
	function automatic logic hit(input ases_pkg::ases_cmd_s c,
		input ases_pkg::ases_reg_e r, input logic wr);
		hit = c.valid && (c.write == wr) && (c.sel == r);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// state

	logic [1:0] sync1_reg;
	logic [1:0] sync2_reg;
	ases_pkg::ases_set_s lay_reg;
	ases_pkg::ases_set_s arm_reg;
	logic lay_sum_reg;
	logic arm_sum_reg;
	logic [15:0] rd_data_reg;
	logic rd_valid_reg;
	logic [15:0] lay_set;
	logic [15:0] arm_set;
	logic [15:0] arm_cond;
	logic [15:0] lay_evt_next;
	logic [15:0] arm_evt_next;
	logic [15:0] rd_mux;

	////////////////////////////////////////////////////////////////////////
	// pin synchroniser: first stage only feeds the second

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			sync1_reg <= 2'h0;
			sync2_reg <= 2'h0;
		end
		else if (clk_en_i)
		begin
			sync1_reg <= {in_scan_layer_i, in_arm_layer1_i};
			sync2_reg <= sync1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequence (layer) condition and its previous value

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			lay_reg.cond <= 16'h0000;
			lay_reg.prev <= 16'h0000;
		end
		else if (clk_en_i)
		begin
			lay_reg.cond <= 16'h0000;
			lay_reg.cond[`ASES_LAYER1_BIT] <= sync2_reg[0];
			lay_reg.cond[`ASES_SCAN_BIT] <= sync2_reg[1];
			lay_reg.prev <= lay_reg.cond;
		end
	end

	// arm condition carries only the sequence summary
	always_comb
	begin
		arm_cond = 16'h0000;
		arm_cond[`ASES_ARM_B1_BIT] = lay_sum_reg;
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			arm_reg.cond <= 16'h0000;
			arm_reg.prev <= 16'h0000;
		end
		else if (clk_en_i)
		begin
			arm_reg.cond <= arm_cond;
			arm_reg.prev <= arm_reg.cond;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transition filters: preset wins over a write in the same cycle

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			arm_reg.rise <= `ASES_RISE_RST;
			arm_reg.fall <= `ASES_FALL_RST;
			lay_reg.rise <= `ASES_RISE_RST;
			lay_reg.fall <= `ASES_FALL_RST;
		end
		else if (clk_en_i)
		begin
			if (preset_i)
			begin
				arm_reg.rise <= `ASES_RISE_RST;
				arm_reg.fall <= `ASES_FALL_RST;
				lay_reg.rise <= `ASES_RISE_RST;
				lay_reg.fall <= `ASES_FALL_RST;
			end
			else
			begin
				if (hit(cmd_i, ases_pkg::ASES_ARM_RISE, 1'b1))
					arm_reg.rise <= cmd_i.data;
				if (hit(cmd_i, ases_pkg::ASES_ARM_FALL, 1'b1))
					arm_reg.fall <= cmd_i.data;
				if (hit(cmd_i, ases_pkg::ASES_LAYER_RISE, 1'b1))
					lay_reg.rise <= cmd_i.data;
				if (hit(cmd_i, ases_pkg::ASES_LAYER_FALL, 1'b1))
					lay_reg.fall <= cmd_i.data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// enable masks: preset leaves them alone, only reset or a write changes

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			arm_reg.mask <= `ASES_MASK_RST;
			lay_reg.mask <= `ASES_MASK_RST;
		end
		else if (clk_en_i)
		begin
			if (hit(cmd_i, ases_pkg::ASES_ARM_MASK, 1'b1))
				arm_reg.mask <= cmd_i.data;
			if (hit(cmd_i, ases_pkg::ASES_LAYER_MASK, 1'b1))
				lay_reg.mask <= cmd_i.data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// event latches

	// same per-bit filter on the layer set
	assign lay_set = edge_hits(lay_reg.cond, lay_reg.prev, lay_reg.rise, lay_reg.fall);
	assign arm_set = edge_hits(arm_reg.cond, arm_reg.prev, arm_reg.rise, arm_reg.fall);

	// clear first, then new edges, so a coincident set survives
	always_comb
	begin
		lay_evt_next = lay_reg.evt;
		arm_evt_next = arm_reg.evt;
		if (clear_status_i || hit(cmd_i, ases_pkg::ASES_LAYER_EVT, 1'b0))
			lay_evt_next = `ASES_EVT_RST;
		if (clear_status_i || hit(cmd_i, ases_pkg::ASES_ARM_EVT, 1'b0))
			arm_evt_next = `ASES_EVT_RST;
		lay_evt_next = lay_evt_next | lay_set;
		arm_evt_next = arm_evt_next | arm_set;
	end

	// bits only drop on a clearing action
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			lay_reg.evt <= `ASES_EVT_RST;
			arm_reg.evt <= `ASES_EVT_RST;
		end
		else if (clk_en_i)
		begin
			lay_reg.evt <= lay_evt_next;
			arm_reg.evt <= arm_evt_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// summaries: one cycle each, so arm B1 lags layer events by one cycle

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			lay_sum_reg <= 1'b0;
			arm_sum_reg <= 1'b0;
		end
		else if (clk_en_i)
		begin
			lay_sum_reg <= |(lay_reg.evt & lay_reg.mask);
			arm_sum_reg <= |(arm_reg.evt & arm_reg.mask);
		end
	end

	always_comb
	begin
		oper_wait_arm_o = 16'h0000;
		oper_wait_arm_o[`ASES_WAIT_ARM_BIT] = arm_sum_reg;
	end

	////////////////////////////////////////////////////////////////////////
	// read port: answer one cycle after the command

	// filter reads are plain muxing, no side effect
	always_comb
	begin
		rd_mux = 16'h0000;
		unique case (cmd_i.sel)
			ases_pkg::ASES_ARM_COND: rd_mux = arm_reg.cond;
			ases_pkg::ASES_ARM_RISE: rd_mux = arm_reg.rise;
			ases_pkg::ASES_ARM_FALL: rd_mux = arm_reg.fall;
			ases_pkg::ASES_ARM_EVT: rd_mux = arm_reg.evt;
			ases_pkg::ASES_ARM_MASK: rd_mux = arm_reg.mask;
			ases_pkg::ASES_LAYER_COND: rd_mux = lay_reg.cond;
			ases_pkg::ASES_LAYER_RISE: rd_mux = lay_reg.rise;
			ases_pkg::ASES_LAYER_FALL: rd_mux = lay_reg.fall;
			ases_pkg::ASES_LAYER_EVT: rd_mux = lay_reg.evt;
			ases_pkg::ASES_LAYER_MASK: rd_mux = lay_reg.mask;
			default: rd_mux = 16'h0000; // illegal select reads zero
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rd_data_reg <= 16'h0000;
			rd_valid_reg <= 1'b0;
		end
		else if (clk_en_i)
		begin
			rd_valid_reg <= cmd_i.valid && !cmd_i.write;
			if (cmd_i.valid && !cmd_i.write)
				rd_data_reg <= rd_mux;
		end
	end

	assign rd_data_o = rd_data_reg;
	assign rd_valid_o = rd_valid_reg;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!resetn_i);

	a_evt_latched: assert property (clk_en_i && !clear_status_i && !cmd_i.valid
		|=> (lay_reg.evt & $past(lay_reg.evt)) == $past(lay_reg.evt))
		else $error("layer event bit dropped without a clear");
	a_rise_sets: assert property (clk_en_i && lay_reg.cond[`ASES_SCAN_BIT]
		&& !lay_reg.prev[`ASES_SCAN_BIT] && lay_reg.rise[`ASES_SCAN_BIT]
		|=> lay_reg.evt[`ASES_SCAN_BIT])
		else $error("rising edge did not set event");
	a_read_clears: assert property (clk_en_i && hit(cmd_i, ases_pkg::ASES_ARM_EVT, 1'b0)
		|=> arm_reg.evt == $past(arm_set) && rd_valid_o && rd_data_o == $past(arm_reg.evt))
		else $error("arm event read did not return then clear");
	a_set_wins: assert property (clk_en_i && clear_status_i && lay_set != 16'h0000
		|=> (lay_reg.evt & $past(lay_set)) == $past(lay_set))
		else $error("event lost in clearing cycle");
	a_preset_filt: assert property (clk_en_i && preset_i
		|=> arm_reg.rise == 16'hffff && arm_reg.fall == 16'h0000
		&& lay_reg.rise == 16'hffff && lay_reg.fall == 16'h0000)
		else $error("preset did not restore filters");
	a_mask_kept: assert property (clk_en_i && !hit(cmd_i, ases_pkg::ASES_LAYER_MASK, 1'b1)
		|=> $stable(lay_reg.mask))
		else $error("layer mask changed without a write");
	a_filt_read: assert property (clk_en_i && hit(cmd_i, ases_pkg::ASES_ARM_RISE, 1'b0)
		&& !preset_i |=> $stable(arm_reg.rise) && rd_data_o == arm_reg.rise)
		else $error("filter read disturbed contents");
	a_wait_arm: assert property (clk_en_i && arm_reg.evt[`ASES_ARM_B1_BIT]
		&& arm_reg.mask[`ASES_ARM_B1_BIT] |=> oper_wait_arm_o[`ASES_WAIT_ARM_BIT])
		else $error("unmasked arm event did not raise waiting-for-arm");
	a_chain_b1: assert property (clk_en_i && (lay_reg.evt & lay_reg.mask) == 16'h0000
		|=> !arm_cond[`ASES_ARM_B1_BIT])
		else $error("arm B1 set with no enabled layer event");
	a_undef_zero: assert property ((lay_reg.cond & ~`ASES_LAYER_DEF) == 16'h0000
		&& (arm_reg.cond & ~`ASES_ARM_DEF) == 16'h0000)
		else $error("undefined condition bit set");

	c_layer_evt: cover property (clk_en_i && lay_set[`ASES_LAYER1_BIT]);
	c_wait_arm: cover property ($rose(oper_wait_arm_o[`ASES_WAIT_ARM_BIT]));
	c_clear_race: cover property (clk_en_i && clear_status_i && arm_set != 16'h0000);
	c_read_evt: cover property (clk_en_i && hit(cmd_i, ases_pkg::ASES_LAYER_EVT, 1'b0)
		&& lay_reg.evt != 16'h0000);

endmodule

`default_nettype wire

/* test/ases_ctrl_model.sv */
// remote controller model: issues decoded status reads and writes
// assumes clock enable held high and one access in flight at a time
`default_nettype none

module ases_ctrl_model
(
	input wire logic sys_clk_i,
	input wire logic [15:0] rd_data_i,
	input wire logic rd_valid_i,
	output var ases_pkg::ases_cmd_s cmd_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// idle bus at time zero
	initial
	begin
		cmd_o = '0;
	end

	////////////////////////////////////////////////////////////////////////
	// one access; released data is inverted so a stale word never looks valid
	task automatic put(input logic wr, input ases_pkg::ases_reg_e r, input logic [15:0] d);
		@(posedge sys_clk_i);
		#1;
		cmd_o = {1'b1, wr, r, d};
		@(posedge sys_clk_i);
		#1;
		cmd_o = {1'b0, wr, r, ~d};
	endtask

	// read: answer pulse is looked for in a few cycles only
	task automatic get(input ases_pkg::ases_reg_e r, output logic [15:0] d, output logic ok);
		put(1'b0, r, 16'h0000);
		ok = 1'b0;
		d = 16'h0000;
		for (int i = 0; i < 4 && !ok; i++)
		begin
			if (rd_valid_i === 1'b1)
			begin
				ok = 1'b1;
				d = rd_data_i;
			end
			else
				@(posedge sys_clk_i) #1;
		end
	endtask
endmodule

`default_nettype wire

/* test/arm_sequence_event_status_test.sv */
// bench for the arm/sequence cascade: register accesses and layer pins
// assumes the controller model owns the command bus
`default_nettype none

module arm_sequence_event_status_test;
	timeunit 1ns;
	timeprecision 100ps;

	logic sys_clk, resetn, clk_en, layer1, scan, preset, clr, rd_valid;
	logic [15:0] rd_data, wait_arm;
	ases_pkg::ases_cmd_s cmd;
	int error_cnt = 0;
	int n_checks = 0;

	ases_top DUT
	(
		.sys_clk_i(sys_clk),
		.resetn_i(resetn),
		.clk_en_i(clk_en),
		.in_arm_layer1_i(layer1),
		.in_scan_layer_i(scan),
		.cmd_i(cmd),
		.preset_i(preset),
		.clear_status_i(clr),
		.rd_data_o(rd_data),
		.rd_valid_o(rd_valid),
		.oper_wait_arm_o(wait_arm)
	);

	ases_ctrl_model ctrl
	(
		.sys_clk_i(sys_clk),
		.rd_data_i(rd_data),
		.rd_valid_i(rd_valid),
		.cmd_o(cmd)
	);

	// 4 ns clock
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// a missing answer ends the run at once
	task automatic rd(input ases_pkg::ases_reg_e r, input logic [15:0] exp);
		logic [15:0] d;
		logic ok;
		ctrl.get(r, d, ok);
		if (!ok)
		begin
			error_cnt++;
			results();
		end
		else
			chk(r.name(), d, exp);
	endtask

	task automatic wr(input ases_pkg::ases_reg_e r, input logic [15:0] d);
		ctrl.put(1'b1, r, d);
	endtask

	// pin changes land just after an edge; pin to summary takes 8 cycles
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		resetn = 1'b0;
		clk_en = 1'b1;
		layer1 = 1'b0;
		scan = 1'b0;
		preset = 1'b0;
		clr = 1'b0;
		wt(16);
		resetn = 1'b1;
		rd(ases_pkg::ASES_ARM_RISE, 16'hffff);
		rd(ases_pkg::ASES_ARM_FALL, 16'h0000);
		rd(ases_pkg::ASES_LAYER_RISE, 16'hffff);
		rd(ases_pkg::ASES_LAYER_FALL, 16'h0000);
		rd(ases_pkg::ASES_ARM_MASK, 16'h0000);
		rd(ases_pkg::ASES_LAYER_MASK, 16'h0000);
		rd(ases_pkg::ASES_ARM_EVT, 16'h0000);
		rd(ases_pkg::ASES_LAYER_EVT, 16'h0000);
		$display("reset test done");
		// both edges on layer bits, then a masked summary
		wr(ases_pkg::ASES_LAYER_FALL, 16'h0006);
		rd(ases_pkg::ASES_LAYER_FALL, 16'h0006);
		rd(ases_pkg::ASES_LAYER_FALL, 16'h0006);
		layer1 = 1'b1;
		wt(10);
		rd(ases_pkg::ASES_LAYER_COND, 16'h0002);
		rd(ases_pkg::ASES_LAYER_EVT, 16'h0002);
		rd(ases_pkg::ASES_LAYER_EVT, 16'h0000);
		scan = 1'b1;
		layer1 = 1'b0;
		wt(10);
		// events are latched but masked, so arm B1 must stay low
		rd(ases_pkg::ASES_ARM_COND, 16'h0000);
		rd(ases_pkg::ASES_LAYER_EVT, 16'h0006);
		wr(ases_pkg::ASES_LAYER_COND, 16'hffff);
		rd(ases_pkg::ASES_LAYER_COND, 16'h0004);
		$display("layer test done");
		// cascade into the arm set and the waiting-for-arm bit
		wr(ases_pkg::ASES_LAYER_MASK, 16'h0004);
		scan = 1'b0;
		wt(10);
		rd(ases_pkg::ASES_ARM_COND, 16'h0002);
		chk("wait_arm", wait_arm, 16'h0000);
		wr(ases_pkg::ASES_ARM_MASK, 16'h0002);
		wt(3);
		chk("wait_arm", wait_arm, 16'h0040);
		rd(ases_pkg::ASES_ARM_MASK, 16'h0002);
		rd(ases_pkg::ASES_ARM_EVT, 16'h0002);
		wt(3);
		chk("wait_arm", wait_arm, 16'h0000);
		rd(ases_pkg::ASES_LAYER_EVT, 16'h0004);
		wt(10);
		rd(ases_pkg::ASES_ARM_EVT, 16'h0000);
		rd(ases_pkg::ASES_ARM_COND, 16'h0000);
		$display("cascade test done");
		// clear-status and preset; preset leaves masks alone
		layer1 = 1'b1;
		wt(10);
		clr = 1'b1;
		wt(1);
		clr = 1'b0;
		rd(ases_pkg::ASES_LAYER_EVT, 16'h0000);
		wr(ases_pkg::ASES_ARM_RISE, 16'h1234);
		preset = 1'b1;
		wt(1);
		preset = 1'b0;
		rd(ases_pkg::ASES_ARM_RISE, 16'hffff);
		rd(ases_pkg::ASES_LAYER_FALL, 16'h0000);
		rd(ases_pkg::ASES_LAYER_MASK, 16'h0004);
		// clear-status lands in the cycle the edge is found: the set must win
		layer1 = 1'b0;
		wt(10);
		layer1 = 1'b1;
		wt(3);
		clr = 1'b1;
		wt(1);
		clr = 1'b0;
		rd(ases_pkg::ASES_LAYER_EVT, 16'h0002);
		// enable low freezes the chain, so the old level is still shown
		clk_en = 1'b0;
		layer1 = 1'b0;
		wt(10);
		clk_en = 1'b1;
		rd(ases_pkg::ASES_LAYER_COND, 16'h0002);
		$display("clear test done");
		results();
	end
endmodule

`default_nettype wire
